// >>> xcvr_pkg.sv
package xcvr_pkg;

    // ==========================================================
    // clock and timing
    localparam int MCLK_MHZ     = 125;
    localparam int CAL_TIME_US  = 256;
    // longest calibration time, rounded down to whole cycles
    localparam int CAL_CYCLES   = (CAL_TIME_US * MCLK_MHZ * 1000) / 1000;

    // ==========================================================
    // frequency plan
    localparam int IF2_KHZ      = 1536;
    localparam int FREQ_W       = 24;
    localparam int CHAN_BITS    = 12;

    // ==========================================================
    // serial control word layout
    localparam int WORD_BITS    = 16;
    localparam int DATA_BITS    = 14;
    localparam int ADDR_BITS    = 2;
    localparam int CNT_BITS     = 5;
    localparam logic [ADDR_BITS-1:0] ADDR_PLL  = 2'h0;
    localparam logic [ADDR_BITS-1:0] ADDR_CHAN = 2'h1;
    localparam logic [ADDR_BITS-1:0] ADDR_TEST = 2'h2;
    localparam int REF_SEL_HI   = 3;
    localparam int REF_SEL_LO   = 1;

    // ==========================================================
    // filter tuning
    localparam int TUNE_W       = 6;
    localparam int NFILT        = 4;
    localparam int FILT_TXLPF   = 3;
    localparam logic [TUNE_W-1:0] TUNE_MID = 6'h20;
    localparam logic [TUNE_W-1:0] TUNE_MAX = 6'h3F;
    localparam logic [TUNE_W-1:0] TUNE_MIN = 6'h00;

    // ==========================================================
    // calibration tick period per reference frequency, in mclk cycles
    localparam int TICK_W = 5;
    localparam logic [TICK_W-1:0] TICK_REF9  = 5'h10;
    localparam logic [TICK_W-1:0] TICK_REF12 = 5'h0C;
    localparam logic [TICK_W-1:0] TICK_REF18 = 5'h08;
    localparam logic [TICK_W-1:0] TICK_REF24 = 5'h06;

    typedef enum logic [1:0] {MODE_STANDBY, MODE_RECEIVE, MODE_TRANSMIT} mode_t;

    typedef struct packed {
        logic [DATA_BITS-1:0] test;
        logic [CHAN_BITS-1:0] channel;
        logic [DATA_BITS-1:0] pll;
    } cfg_regs_t;

    localparam cfg_regs_t CFG_RESET = '0;

    typedef struct packed {
        logic standby;
        logic rx_on;
        logic tx_on;
        logic lo_shift;
        logic cal_busy;
    } status_t;

    // reference select code to calibration tick period
    function automatic logic [TICK_W-1:0] tick_period(input logic [1:0] sel);
        case (sel)
            2'h0:    tick_period = TICK_REF9;
            2'h1:    tick_period = TICK_REF12;
            2'h2:    tick_period = TICK_REF18;
            default: tick_period = TICK_REF24;
        endcase
    endfunction

    // carrier in kHz from the channel word
    function automatic logic [FREQ_W-1:0] carrier_khz(input logic [CHAN_BITS-1:0] ch);
        carrier_khz = FREQ_W'({12'h000, ch} * 24'(IF2_KHZ));
    endfunction

endpackage

// >>> serial_word_loader.sv
`timescale 1ns/1ps
module serial_word_loader (
    input  wire logic                            mclk,
    input  wire logic                            srst,
    input  wire logic                            ser_clk,
    input  wire logic                            ser_data,
    input  wire logic                            ser_strobe_n,
    output logic                                 load_pulse,
    output logic [xcvr_pkg::ADDR_BITS-1:0]       load_addr,
    output logic [xcvr_pkg::DATA_BITS-1:0]       load_data
);
    logic                                 clk_prev_r;
    logic                                 stb_prev_r;
    logic [xcvr_pkg::WORD_BITS-1:0]       shift_r;
    logic [xcvr_pkg::CNT_BITS-1:0]        cnt_r;

    localparam logic [xcvr_pkg::CNT_BITS-1:0] FULL = 5'h10;

    // ==========================================================
    // edge history of the serial pins
    always_ff @(posedge mclk) begin
        if (srst) begin
            clk_prev_r <= 1'b0;
            stb_prev_r <= 1'b1;
        end else begin
            clk_prev_r <= ser_clk;
            stb_prev_r <= ser_strobe_n;
        end
    end

    // shift msb first while the strobe is low; clock ignored while high
    always_ff @(posedge mclk) begin
        if (srst) begin
            shift_r <= '0;
            cnt_r   <= '0;
        end else if (ser_strobe_n && !stb_prev_r) begin
            cnt_r <= '0;
        end else if (!ser_strobe_n && ser_clk && !clk_prev_r) begin
            shift_r <= {shift_r[xcvr_pkg::WORD_BITS-2:0], ser_data}; // [R17] [R16]
            if (cnt_r != FULL) begin
                cnt_r <= cnt_r + 5'h01;
            end
        end
    end

    // load on strobe rising edge; short words are dropped as a safe choice
    always_ff @(posedge mclk) begin
        if (srst) begin
            load_pulse <= 1'b0;
            load_addr  <= '0;
            load_data  <= '0;
        end else begin
            load_pulse <= ser_strobe_n && !stb_prev_r && (cnt_r == FULL); // [R17]
            load_addr  <= shift_r[xcvr_pkg::ADDR_BITS-1:0]; // [R16]
            load_data  <= shift_r[xcvr_pkg::WORD_BITS-1:xcvr_pkg::ADDR_BITS];
        end
    end

    property p_load_on_rise;
        @(posedge mclk) disable iff (srst)
        load_pulse |-> $past(ser_strobe_n) && !$past(ser_strobe_n, 2);
    endproperty
    a_load_on_rise: assert property (p_load_on_rise) else $error("load off strobe edge"); // [R17]

    property p_full_word;
        @(posedge mclk) disable iff (srst)
        load_pulse |-> $past(cnt_r) == FULL;
    endproperty
    a_full_word: assert property (p_full_word) else $error("load without 16 bits"); // [R16]

endmodule

// >>> filter_cal_engine.sv
`timescale 1ns/1ps
module filter_cal_engine #(
    parameter int CAL_CYCLES = xcvr_pkg::CAL_CYCLES
) (
    input  wire logic                                          mclk,
    input  wire logic                                          srst,
    input  wire logic                                          start,
    input  wire logic                                          abort,
    input  wire logic                                          track_tx,
    input  wire logic [1:0]                                    ref_sel,
    input  wire logic [xcvr_pkg::NFILT-1:0]                    cmp_high,
    output logic                                               busy,
    output logic [xcvr_pkg::NFILT-1:0][xcvr_pkg::TUNE_W-1:0]   tune
);
    localparam int CW = $clog2(CAL_CYCLES + 1);
    localparam logic [CW-1:0] CAL_LAST = CW'(CAL_CYCLES - 1);

    logic [xcvr_pkg::TICK_W-1:0] div_r;
    logic [CW-1:0]               cnt_r;
    logic                        tick;

    // ==========================================================
    // tick derived from the selected reference rate
    assign tick = (div_r == '0);

    always_ff @(posedge mclk) begin
        if (srst || start) begin
            div_r <= '0;
        end else if (tick) begin
            div_r <= xcvr_pkg::TICK_W'(xcvr_pkg::tick_period(ref_sel) - 5'h01); // [R15]
        end else begin
            div_r <= div_r - 5'h01;
        end
    end

    // bounded calibration window; standby cuts it short
    always_ff @(posedge mclk) begin
        if (srst || abort) begin
            busy  <= 1'b0;
            cnt_r <= '0;
        end else if (start) begin
            busy  <= 1'b1; // [R4] [R6]
            cnt_r <= '0;
        end else if (busy) begin
            cnt_r <= cnt_r + CW'(1);
            if (cnt_r == CAL_LAST) begin
                busy <= 1'b0; // [R4]
            end
        end
    end

    // successive step toward the comparator balance point
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < xcvr_pkg::NFILT; i++) begin
                tune[i] <= xcvr_pkg::TUNE_MID; // [R7]
            end
        end else if (tick && !abort) begin
            for (int i = 0; i < xcvr_pkg::NFILT; i++) begin
                if (busy || (track_tx && i == xcvr_pkg::FILT_TXLPF)) begin // [R8]
                    if (cmp_high[i] && tune[i] != xcvr_pkg::TUNE_MIN) begin
                        tune[i] <= tune[i] - 6'h01;
                    end else if (!cmp_high[i] && tune[i] != xcvr_pkg::TUNE_MAX) begin
                        tune[i] <= tune[i] + 6'h01;
                    end
                end
            end
        end
    end

    property p_tune_mid;
        @(posedge mclk) srst |=> tune[0] == xcvr_pkg::TUNE_MID && tune[3] == xcvr_pkg::TUNE_MID;
    endproperty
    a_tune_mid: assert property (p_tune_mid) else $error("tuning not mid after reset"); // [R7]

    property p_tick_gap;
        @(posedge mclk) disable iff (srst || start)
        tick |=> !tick [*5];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("reference tick too fast"); // [R15]

    property p_cal_bound;
        @(posedge mclk) disable iff (srst)
        busy |-> cnt_r <= CAL_LAST;
    endproperty
    a_cal_bound: assert property (p_cal_bound) else $error("calibration overran"); // [R4]

endmodule

// >>> transceiver_mode_sequencer.sv
// What this block and its controller must do
// R1 - enable low forces standby regardless of receive-select
// R2 - enable high: select 1 receive, 0 transmit
// R3 - serial interface and registers live in standby
// R4 - enable rising edge runs calibration within 256us
// R5 - controller holds receive 256us after standby exit
// R6 - entering receive starts automatic filter tuning
// R7 - tuning values start at mid-range
// R8 - transmit filter tuning refreshed every receive
// R9 - LO shifts by second IF between modes
// R10 - carrier equals channel word times 1.536MHz
// R11 - channel word accepted and retuned any time
// R12 - one channel value serves receive and transmit
// R13 - controller waits for lock and alignment
// R14 - receive mode drives sliced NRZ data out
// R15 - reference frequency selected by configuration
// R16 - 16-bit word, 14 data then 2 address
// R17 - shift on clock rise, load on strobe rise
// R18 - mode lines synchronised before the state machine
`timescale 1ns/1ps
module transceiver_mode_sequencer #(
    parameter int CAL_CYCLES = xcvr_pkg::CAL_CYCLES
) (
    input  wire logic                                          mclk,
    input  wire logic                                          srst,
    input  wire logic                                          transceiver_enable,
    input  wire logic                                          receive_select,
    input  wire logic                                          ser_clk,
    input  wire logic                                          ser_data,
    input  wire logic                                          ser_strobe_n,
    input  wire logic                                          demod_bit,
    input  wire logic [xcvr_pkg::NFILT-1:0]                    filter_cmp,
    output xcvr_pkg::status_t                                  status,
    output logic                                               data_out,
    output logic [xcvr_pkg::FREQ_W-1:0]                        carrier_khz,
    output logic [xcvr_pkg::FREQ_W-1:0]                        lo_khz,
    output xcvr_pkg::cfg_regs_t                                cfg,
    output logic [xcvr_pkg::NFILT-1:0][xcvr_pkg::TUNE_W-1:0]   tune
);
    // ==========================================================
    // declarations
    logic                                en_meta_r;
    logic                                en_sync_r;
    logic                                rx_meta_r;
    logic                                rx_sync_r;
    logic                                en_prev_r;
    xcvr_pkg::mode_t                     mode_r;
    xcvr_pkg::mode_t                     mode_nxt;
    logic                                cal_start;
    logic                                cal_busy;
    logic                                load_pulse;
    logic [xcvr_pkg::ADDR_BITS-1:0]      load_addr;
    logic [xcvr_pkg::DATA_BITS-1:0]      load_data;
    logic [xcvr_pkg::FREQ_W-1:0]         carrier_nxt;
    logic [1:0]                          ref_sel;
    logic [15:0]                         busy_run_r;
    logic                                cal_start_r;

    localparam logic [xcvr_pkg::FREQ_W-1:0] IF2 = xcvr_pkg::FREQ_W'(xcvr_pkg::IF2_KHZ);

    // ==========================================================
    // mode line synchronisers; the meta stage feeds only the sync stage
    always_ff @(posedge mclk) begin
        if (srst) begin
            en_meta_r <= 1'b0;
            en_sync_r <= 1'b0;
            rx_meta_r <= 1'b0;
            rx_sync_r <= 1'b0;
        end else begin
            en_meta_r <= transceiver_enable; // [R18]
            en_sync_r <= en_meta_r;
            rx_meta_r <= receive_select;
            rx_sync_r <= rx_meta_r;
        end
    end

    // enable history for rising edge detection
    always_ff @(posedge mclk) begin
        if (srst) begin
            en_prev_r <= 1'b0;
        end else begin
            en_prev_r <= en_sync_r;
        end
    end

    // ==========================================================
    // mode decode from the synchronised lines
    always_comb begin
        case ({en_sync_r, rx_sync_r})
            2'b11:   mode_nxt = xcvr_pkg::MODE_RECEIVE;  // [R2]
            2'b10:   mode_nxt = xcvr_pkg::MODE_TRANSMIT; // [R2]
            default: mode_nxt = xcvr_pkg::MODE_STANDBY;  // [R1]
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_r <= xcvr_pkg::MODE_STANDBY;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // calibration kicks on enable edge or on any entry into receive
    assign cal_start = (en_sync_r && !en_prev_r) // [R4]
                     || (mode_nxt == xcvr_pkg::MODE_RECEIVE
                         && mode_r != xcvr_pkg::MODE_RECEIVE); // [R6]

    // ==========================================================
    // serial control port and register file
    serial_word_loader u_loader (
        .mclk         (mclk),
        .srst         (srst),
        .ser_clk      (ser_clk),
        .ser_data     (ser_data),
        .ser_strobe_n (ser_strobe_n),
        .load_pulse   (load_pulse),
        .load_addr    (load_addr),
        .load_data    (load_data)
    );

    // writes land in every mode, standby included; only srst clears them
    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg <= xcvr_pkg::CFG_RESET;
        end else if (load_pulse) begin
            case (load_addr) // [R3]
                xcvr_pkg::ADDR_PLL:  cfg.pll     <= load_data;
                xcvr_pkg::ADDR_CHAN: cfg.channel <= load_data[xcvr_pkg::CHAN_BITS-1:0]; // [R11]
                xcvr_pkg::ADDR_TEST: cfg.test    <= load_data;
                default: ;
            endcase
        end
    end

    assign ref_sel = {cfg.pll[xcvr_pkg::REF_SEL_HI], cfg.pll[xcvr_pkg::REF_SEL_LO]}; // [R15]

    // ==========================================================
    // filter calibration
    filter_cal_engine #(
        .CAL_CYCLES (CAL_CYCLES)
    ) u_cal (
        .mclk     (mclk),
        .srst     (srst),
        .start    (cal_start),
        .abort    (mode_nxt == xcvr_pkg::MODE_STANDBY),
        .track_tx (mode_r == xcvr_pkg::MODE_RECEIVE), // [R8]
        .ref_sel  (ref_sel),
        .cmp_high (filter_cmp),
        .busy     (cal_busy),
        .tune     (tune)
    );

    // ==========================================================
    // frequency plan: carrier from the one channel word, LO shifted in receive
    assign carrier_nxt = xcvr_pkg::carrier_khz(cfg.channel); // [R10] [R12]

    always_ff @(posedge mclk) begin
        if (srst) begin
            carrier_khz <= '0;
            lo_khz      <= '0;
        end else begin
            carrier_khz <= carrier_nxt;
            if (mode_nxt == xcvr_pkg::MODE_RECEIVE) begin
                // saturate instead of wrapping below the lowest channel
                lo_khz <= (carrier_nxt < IF2) ? '0 : carrier_nxt - IF2; // [R9]
            end else begin
                lo_khz <= carrier_nxt;
            end
        end
    end

    // ==========================================================
    // status flags registered from the decoded next mode, except cal_busy registered from the engine
    always_ff @(posedge mclk) begin
        if (srst) begin
            status <= '{standby: 1'b1, default: 1'b0};
        end else begin
            status.standby  <= (mode_nxt == xcvr_pkg::MODE_STANDBY);  // [R1]
            status.rx_on    <= (mode_nxt == xcvr_pkg::MODE_RECEIVE);  // [R2]
            status.tx_on    <= (mode_nxt == xcvr_pkg::MODE_TRANSMIT); // [R2]
            status.lo_shift <= (mode_nxt == xcvr_pkg::MODE_RECEIVE);  // [R9]
            status.cal_busy <= cal_busy;
        end
    end

    // sliced data only leaves the pin in receive; quiet low otherwise
    always_ff @(posedge mclk) begin
        if (srst) begin
            data_out <= 1'b0;
        end else begin
            data_out <= (mode_nxt == xcvr_pkg::MODE_RECEIVE) && demod_bit; // [R14]
        end
    end

    // ==========================================================
    // checks: start seen one cycle late, so a restart clears the count in step with status
    always_ff @(posedge mclk) begin
        if (srst) begin
            cal_start_r <= 1'b0;
        end else begin
            cal_start_r <= cal_start;
        end
    end

    // helper counter of consecutive busy cycles
    always_ff @(posedge mclk) begin
        if (srst || !status.cal_busy || cal_start_r) begin
            busy_run_r <= '0;
        end else if (busy_run_r != 16'hFFFF) begin
            busy_run_r <= busy_run_r + 16'h0001;
        end
    end

    sequence s_enable_rise;
        en_sync_r && !en_prev_r;
    endsequence

    sequence s_cal_seen;
        ##2 status.cal_busy;
    endsequence

    property p_standby;
        @(posedge mclk) disable iff (srst)
        !en_sync_r |=> status.standby && !status.rx_on && !status.tx_on;
    endproperty
    a_standby: assert property (p_standby) else $error("not standby with enable low"); // [R1]

    property p_rx_mode;
        @(posedge mclk) disable iff (srst)
        en_sync_r && rx_sync_r |=> status.rx_on && !status.tx_on;
    endproperty
    a_rx_mode: assert property (p_rx_mode) else $error("receive not entered"); // [R2]

    property p_tx_mode;
        @(posedge mclk) disable iff (srst)
        en_sync_r && !rx_sync_r |=> status.tx_on && !status.rx_on;
    endproperty
    a_tx_mode: assert property (p_tx_mode) else $error("transmit not entered"); // [R2]

    property p_sync_delay;
        @(posedge mclk) disable iff (srst)
        $rose(transceiver_enable) ##1 transceiver_enable |=> en_sync_r;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("enable sync latency wrong"); // [R18]

    property p_cfg_standby_load;
        @(posedge mclk) disable iff (srst)
        load_pulse && load_addr == xcvr_pkg::ADDR_CHAN
        |=> cfg.channel == $past(load_data[xcvr_pkg::CHAN_BITS-1:0]);
    endproperty
    a_cfg_standby_load: assert property (p_cfg_standby_load) else $error("channel write lost"); // [R3]

    property p_cfg_hold;
        @(posedge mclk) disable iff (srst)
        !load_pulse |=> $stable(cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write"); // [R3]

    property p_cal_on_edge;
        @(posedge mclk) disable iff (srst)
        s_enable_rise ##1 en_sync_r |-> s_cal_seen;
    endproperty
    a_cal_on_edge: assert property (p_cal_on_edge) else $error("no calibration on enable"); // [R4]

    property p_cal_len;
        @(posedge mclk) disable iff (srst)
        status.cal_busy |-> busy_run_r < 16'(CAL_CYCLES);
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration too long"); // [R4]

    property p_cal_on_rx;
        @(posedge mclk) disable iff (srst)
        mode_nxt == xcvr_pkg::MODE_RECEIVE && mode_r == xcvr_pkg::MODE_TRANSMIT
        ##1 mode_r == xcvr_pkg::MODE_RECEIVE |-> ##1 status.cal_busy;
    endproperty
    a_cal_on_rx: assert property (p_cal_on_rx) else $error("no calibration on receive"); // [R6]

    property p_carrier;
        @(posedge mclk) disable iff (srst)
        load_pulse && load_addr == xcvr_pkg::ADDR_CHAN
        |-> ##2 carrier_khz
            == xcvr_pkg::FREQ_W'({12'h000, $past(load_data[xcvr_pkg::CHAN_BITS-1:0], 2)} * IF2);
    endproperty
    a_carrier: assert property (p_carrier) else $error("carrier mismatch"); // [R10]

    property p_lo_shift;
        @(posedge mclk) disable iff (srst)
        status.rx_on && carrier_khz >= IF2 |-> lo_khz == carrier_khz - IF2;
    endproperty
    a_lo_shift: assert property (p_lo_shift) else $error("receive LO not shifted"); // [R9]

    property p_lo_tx;
        @(posedge mclk) disable iff (srst)
        !status.rx_on |-> lo_khz == carrier_khz;
    endproperty
    a_lo_tx: assert property (p_lo_tx) else $error("transmit LO shifted"); // [R9]

    property p_one_channel;
        @(posedge mclk) disable iff (srst)
        $changed(status.rx_on) && $stable(cfg.channel)
        && $past(cfg.channel) == $past(cfg.channel, 2)
        |-> $stable(carrier_khz);
    endproperty
    a_one_channel: assert property (p_one_channel) else $error("carrier moved on switch"); // [R12]

    property p_data_rx;
        @(posedge mclk) disable iff (srst)
        status.rx_on |-> data_out == $past(demod_bit);
    endproperty
    a_data_rx: assert property (p_data_rx) else $error("data out not following slicer"); // [R14]

    property p_data_quiet;
        @(posedge mclk) disable iff (srst)
        !status.rx_on |-> !data_out;
    endproperty
    a_data_quiet: assert property (p_data_quiet) else $error("data out active outside rx"); // [R14]

endmodule

// >>> bb_ctrl_model.sv
`timescale 1ns/1ps
// ==========================================================
// baseband controller: mode lines and three-wire serial bus
module bb_ctrl_model (
    input  wire logic mclk,
    output logic      transceiver_enable,
    output logic      receive_select,
    output logic      ser_clk,
    output logic      ser_data,
    output logic      ser_strobe_n
);
    // idle bus: clock parked low, strobe high
    initial begin
        transceiver_enable = 1'b0;
        receive_select     = 1'b0;
        ser_clk            = 1'b0;
        ser_data           = 1'b1;
        ser_strobe_n       = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // caller keeps receive for the calibration time before transmit
    task automatic set_mode(input logic en, input logic sel);
        tick(1);
        transceiver_enable = en;
        receive_select     = sel;
    endtask
    // two mclk per clock phase so the sampled edge detector sees both levels
    task automatic send_word(input logic [13:0] d, input logic [1:0] a);
        logic [15:0] w;
        w = {d, a};
        tick(1);
        ser_strobe_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            ser_data = w[i];
            tick(2);
            ser_clk = 1'b1;
            tick(2);
            ser_clk = 1'b0;
        end
        tick(2);
        ser_strobe_n = 1'b1;
        ser_data     = ~ser_data; // released data must not look held
    endtask
endmodule

// >>> transceiver_mode_sequencer_tb.sv
`timescale 1ns/1ps
module transceiver_mode_sequencer_tb;
    localparam int CALC = 40;
    logic                           mclk;
    logic                           srst;
    logic                           demod_bit;
    logic [3:0]                     filter_cmp;
    logic                           en;
    logic                           sel;
    logic                           sck;
    logic                           sda;
    logic                           sstb_n;
    xcvr_pkg::status_t              status;
    logic                           data_out;
    logic [23:0]                    carrier_khz;
    logic [23:0]                    lo_khz;
    xcvr_pkg::cfg_regs_t            cfg;
    logic [3:0][5:0]                tune;
    int                             error_cnt;
    int                             checks_done;

    transceiver_mode_sequencer #(.CAL_CYCLES(CALC)) u_dut (.mclk(mclk), .srst(srst),
        .transceiver_enable(en), .receive_select(sel), .ser_clk(sck), .ser_data(sda),
        .ser_strobe_n(sstb_n), .demod_bit(demod_bit), .filter_cmp(filter_cmp),
        .status(status), .data_out(data_out), .carrier_khz(carrier_khz), .lo_khz(lo_khz),
        .cfg(cfg), .tune(tune));
    bb_ctrl_model u_bb (.mclk(mclk), .transceiver_enable(en), .receive_select(sel),
        .ser_clk(sck), .ser_data(sda), .ser_strobe_n(sstb_n));

    // ==========================================================
    // clock, compare, verdict
    initial mclk = 1'b0;
    always #4 mclk = ~mclk;
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // channel times second-IF step, in kHz
    function automatic logic [23:0] fc(input logic [11:0] ch);
        return {12'h000, ch} * 24'h000600;
    endfunction

    // ==========================================================
    // scenarios
    task automatic t_standby;
        demod_bit = 1'b1;
        u_bb.set_mode(1'b0, 1'b0);
        u_bb.tick(4);
        chk("status", 24'h000010, 24'(status));
        u_bb.set_mode(1'b0, 1'b1);
        u_bb.send_word(14'h0064, 2'h1);
        u_bb.send_word(14'h000A, 2'h0);
        u_bb.send_word(14'h1234, 2'h2);
        u_bb.send_word(14'h3FFF, 2'h3);
        u_bb.tick(4);
        chk("status", 24'h000010, 24'(status));
        chk("channel", 24'h000064, 24'(cfg.channel));
        chk("pll", 24'h00000A, 24'(cfg.pll));
        chk("test", 24'h001234, 24'(cfg.test));
        chk("carrier", fc(12'h064), carrier_khz);
        chk("data_out", 24'h0, 24'(data_out));
    endtask
    task automatic t_receive;
        int n;
        demod_bit = 1'b1;
        filter_cmp = 4'h6;
        u_bb.set_mode(1'b1, 1'b1);
        u_bb.tick(4);
        chk("status", 24'h00000B, 24'(status));
        chk("cal_busy", 24'h1, 24'(status.cal_busy));
        chk("lo rx", fc(12'h064) - 24'h000600, lo_khz);
        chk("data_out", 24'h1, 24'(data_out));
        demod_bit = 1'b0;
        u_bb.tick(2);
        chk("data_out", 24'h0, 24'(data_out));
        n = 0;
        while (status.cal_busy !== 1'b0 && n < CALC + 8) begin
            u_bb.tick(1);
            n++;
        end
        chk("cal done", 24'h1, 24'(n <= CALC));
        u_bb.tick(200);
        chk("tune up", 24'h1, 24'(tune[0] > 6'h24));
        chk("tune down", 24'h1, 24'(tune[1] < 6'h20));
        chk("tx lpf tracks", 24'h00003F, 24'(tune[3]));
    endtask
    task automatic t_transmit;
        demod_bit = 1'b1;
        u_bb.set_mode(1'b1, 1'b0);
        u_bb.tick(4);
        chk("status", 24'h000004, 24'(status));
        chk("lo tx", fc(12'h064), lo_khz);
        chk("data_out", 24'h0, 24'(data_out));
        u_bb.send_word(14'h00FF, 2'h1);
        u_bb.tick(4);
        chk("retune", fc(12'h0FF), carrier_khz);
        chk("lo retune", fc(12'h0FF), lo_khz);
        u_bb.set_mode(1'b1, 1'b1);
        u_bb.tick(4);
        chk("cal again", 24'h1, 24'(status.cal_busy));
        chk("lo rx again", fc(12'h0FF) - 24'h000600, lo_khz);
        u_bb.set_mode(1'b0, 1'b1);
        u_bb.tick(4);
        chk("abort", 24'h000010, 24'(status));
    endtask

    initial begin
        srst       = 1'b1;
        demod_bit  = 1'b0;
        filter_cmp = 4'hF;
        error_cnt  = 0;
        checks_done = 0;
        repeat (8) @(negedge mclk);
        srst = 1'b0;
        chk("reset status", 24'h000010, 24'(status));
        chk("tune mid", {4{6'h20}}, 24'(tune));
        t_standby();
        t_receive();
        t_transmit();
        close_out();
    end
    // watchdog well past the expected few hundred cycles
    initial begin
        repeat (3000) @(posedge mclk);
        error_cnt++;
        close_out();
    end
endmodule
